// *** verilog/sdcts_timing.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Spacing registers accessible only in configuration or reduced-activity state.
// - Unused upper bits read undefined (zero here); software writes zero.
// - After refresh, block every command for the refresh recovery count.
// - Scheduler spaces commands after refresh by field value plus three.
// - After precharge, block activate for the precharge recovery count.
// - Scheduler spaces activate after precharge by field value plus three.
// - Activates to different banks separated by the cross-bank count.
// - After a write, block precharge to that bank for the count.
// - After a write, block reads for the write turnaround count.
// - After power-down exit, block commands for the programmed count.
// - After self-refresh exit, block commands for the programmed count.
// - After self-refresh entry, block commands for the programmed count.
module sdcts_timing #(
  parameter int BANK_W = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller state
  input wire logic ctl_config,
  input wire logic ctl_low_power,
  // Issued commands, one-cycle pulses
  input wire logic cmd_refresh,
  input wire logic cmd_precharge,
  input wire logic [BANK_W-1:0] pre_bank,
  input wire logic cmd_activate,
  input wire logic [BANK_W-1:0] act_bank,
  input wire logic cmd_write,
  input wire logic [BANK_W-1:0] wr_bank,
  input wire logic pd_exit,
  input wire logic sr_exit,
  input wire logic sr_entry,
  // Permits, combinational
  output logic cmd_any_ok,
  output logic act_ok,
  output logic pre_ok,
  output logic rd_ok
);

  typedef struct packed {
    logic [4:0] rfc_v;
    logic [4:0] srfc_v;
    logic [2:0] rp_v;
    logic [2:0] srp_v;
    logic [3:0] rrd_v;
    logic [2:0] wr_v;
    logic [2:0] wtr_v;
    logic [7:0] xp_v;
    logic [7:0] xsr_v;
    logic [7:0] esr_v;
    logic [4:0] rfc_c;
    logic [5:0] srfc_c;
    logic [2:0] rp_c;
    logic [3:0] srp_c;
    logic [3:0] rrd_c;
    logic [BANK_W-1:0] rrd_bank;
    logic [2:0] wr_c;
    logic [BANK_W-1:0] wr_bank;
    logic [2:0] wtr_c;
    logic [7:0] xp_c;
    logic [7:0] xsr_c;
    logic [7:0] esr_c;
    logic [31:0] rdata;
    logic slverr;
  } sdcts_st_t;

  sdcts_st_t st_r;
  sdcts_st_t st_nxt;

  logic win;
  logic setup;
  logic do_wr;
  logic known;
  logic is_timing;
  logic [9:0] busy;

  function automatic logic [7:0] dec8(input logic [7:0] c);
    return (c == 8'h00) ? 8'h00 : c - 8'h01;
  endfunction

  assign win = ctl_config | ctl_low_power;
  assign setup = psel & ~penable;
  assign is_timing = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
  assign known = is_timing || (paddr == sdcts_pkg::OFS_STATUS);
  // Write commits at the access edge; slave never waits
  assign do_wr = psel & penable & pwrite & win & is_timing;
  assign pready = 1'b1;
  assign prdata = st_r.rdata;
  assign pslverr = st_r.slverr;

  assign busy = {st_r.esr_c != 8'h00, st_r.xsr_c != 8'h00, st_r.xp_c != 8'h00,
                 st_r.wtr_c != 3'h0, st_r.wr_c != 3'h0, st_r.rrd_c != 4'h0,
                 st_r.srp_c != 4'h0, st_r.rp_c != 3'h0, st_r.srfc_c != 6'h00,
                 st_r.rfc_c != 5'h00};

  // Permits look at counters and bank numbers, never at command pulses, so a new
  // command in the same cycle cannot shorten its own spacing
  always_comb begin
    cmd_any_ok = (st_r.rfc_c == 5'h00) && (st_r.srfc_c == 6'h00)
                 && (st_r.xp_c == 8'h00)
                 && (st_r.xsr_c == 8'h00)
                 && (st_r.esr_c == 8'h00);
    act_ok = cmd_any_ok && (st_r.rp_c == 3'h0)
             && (st_r.srp_c == 4'h0)
             && !((st_r.rrd_c != 4'h0) && (act_bank != st_r.rrd_bank));
    pre_ok = cmd_any_ok && !((st_r.wr_c != 3'h0) && (pre_bank == st_r.wr_bank));
    rd_ok = cmd_any_ok && (st_r.wtr_c == 3'h0);
  end

  always_comb begin
    st_nxt = st_r;
    // Register writes
    if (do_wr) begin
      unique case (paddr)
        sdcts_pkg::OFS_RFC: begin
          st_nxt.rfc_v = pwdata[sdcts_pkg::RFC_LSB +: 5];
          st_nxt.srfc_v = pwdata[sdcts_pkg::SRFC_LSB +: 5];
        end
        sdcts_pkg::OFS_RP: begin
          st_nxt.rp_v = pwdata[sdcts_pkg::RP_LSB +: 3];
          st_nxt.srp_v = pwdata[sdcts_pkg::SRP_LSB +: 3];
        end
        sdcts_pkg::OFS_RRD: st_nxt.rrd_v = pwdata[3:0];
        sdcts_pkg::OFS_WR: st_nxt.wr_v = pwdata[2:0];
        sdcts_pkg::OFS_WTR: st_nxt.wtr_v = pwdata[2:0];
        sdcts_pkg::OFS_XP: st_nxt.xp_v = pwdata[7:0];
        sdcts_pkg::OFS_XSR: st_nxt.xsr_v = pwdata[7:0];
        sdcts_pkg::OFS_ESR: st_nxt.esr_v = pwdata[7:0];
        default: ;
      endcase
    end
    // Read data and error prepared in setup, presented in access phase
    if (setup) begin
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.slverr = !known || (is_timing && !win);
      if (!pwrite && win) begin
        unique case (paddr)
          // Upper bits read as zero
          sdcts_pkg::OFS_RFC: st_nxt.rdata = {22'h0, st_r.srfc_v, st_r.rfc_v};
          sdcts_pkg::OFS_RP: st_nxt.rdata = {26'h0, st_r.srp_v, st_r.rp_v};
          sdcts_pkg::OFS_RRD: st_nxt.rdata = {28'h0, st_r.rrd_v};
          sdcts_pkg::OFS_WR: st_nxt.rdata = {29'h0, st_r.wr_v};
          sdcts_pkg::OFS_WTR: st_nxt.rdata = {29'h0, st_r.wtr_v};
          sdcts_pkg::OFS_XP: st_nxt.rdata = {24'h000000, st_r.xp_v};
          sdcts_pkg::OFS_XSR: st_nxt.rdata = {24'h000000, st_r.xsr_v};
          sdcts_pkg::OFS_ESR: st_nxt.rdata = {24'h000000, st_r.esr_v};
          default: ;
        endcase
      end
      if (!pwrite && (paddr == sdcts_pkg::OFS_STATUS)) begin
        st_nxt.rdata = {21'h0, win, busy};
      end
    end
    // Down-counters; a fresh issue reloads and wins over the decrement
    st_nxt.rfc_c = 5'(dec8({3'h0, st_r.rfc_c}));
    st_nxt.srfc_c = 6'(dec8({2'h0, st_r.srfc_c}));
    st_nxt.rp_c = 3'(dec8({5'h00, st_r.rp_c}));
    st_nxt.srp_c = 4'(dec8({4'h0, st_r.srp_c}));
    st_nxt.rrd_c = 4'(dec8({4'h0, st_r.rrd_c}));
    st_nxt.wr_c = 3'(dec8({5'h00, st_r.wr_c}));
    st_nxt.wtr_c = 3'(dec8({5'h00, st_r.wtr_c}));
    st_nxt.xp_c = dec8(st_r.xp_c);
    st_nxt.xsr_c = dec8(st_r.xsr_c);
    st_nxt.esr_c = dec8(st_r.esr_c);
    if (cmd_refresh) begin
      st_nxt.rfc_c = st_r.rfc_v;
      st_nxt.srfc_c = {1'b0, st_r.srfc_v} + sdcts_pkg::SCHED_ADD;
    end
    if (cmd_precharge) begin
      st_nxt.rp_c = st_r.rp_v;
      st_nxt.srp_c = {1'b0, st_r.srp_v} + 4'(sdcts_pkg::SCHED_ADD);
    end
    if (cmd_activate) begin
      st_nxt.rrd_c = st_r.rrd_v;
      st_nxt.rrd_bank = act_bank;
    end
    if (cmd_write) begin
      st_nxt.wr_c = st_r.wr_v;
      st_nxt.wr_bank = wr_bank;
      st_nxt.wtr_c = st_r.wtr_v;
    end
    if (pd_exit) begin
      st_nxt.xp_c = st_r.xp_v;
    end
    if (sr_exit) begin
      st_nxt.xsr_c = st_r.xsr_v;
    end
    if (sr_entry) begin
      st_nxt.esr_c = st_r.esr_v;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.rfc_v <= sdcts_pkg::RST_RFC;
      st_r.srfc_v <= sdcts_pkg::RST_SRFC;
      st_r.rp_v <= sdcts_pkg::RST_RP;
      st_r.srp_v <= sdcts_pkg::RST_SRP;
      st_r.rrd_v <= sdcts_pkg::RST_RRD;
      st_r.wr_v <= sdcts_pkg::RST_WR;
      st_r.wtr_v <= sdcts_pkg::RST_WTR;
      st_r.xp_v <= sdcts_pkg::RST_XP;
      st_r.xsr_v <= sdcts_pkg::RST_XSR;
      st_r.esr_v <= sdcts_pkg::RST_ESR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks
  sequence s_setup_locked;
    psel && !penable && is_timing && !win;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  sequence s_setup_open;
    psel && !penable && is_timing && win;
  endsequence

  a_locked_error: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_locked ##1 s_access |-> pslverr)
    else $error("locked timing access not flagged");

  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access and (!pwrite && paddr == sdcts_pkg::OFS_RFC)) |-> prdata[31:10] == 22'h0)
    else $error("upper bits of refresh register not zero");

  a_rfc_block: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_refresh && st_r.rfc_v != 5'h00) |=> !cmd_any_ok)
    else $error("command allowed right after refresh");

  a_srfc_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_refresh |=> st_r.srfc_c == {1'b0, $past(st_r.srfc_v)} + 6'h03)
    else $error("scheduler refresh spacing wrong");

  a_rp_block: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_precharge |=> !act_ok)
    else $error("activate allowed right after precharge");

  a_srp_three: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_precharge && st_r.srp_v == 3'h0) |=> !act_ok [*3])
    else $error("scheduler precharge spacing under three");

  a_rrd_bank: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_activate && st_r.rrd_v != 4'h0) ##1 (act_bank != $past(act_bank)) |-> !act_ok)
    else $error("cross-bank activate not held off");

  a_wr_pre: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write && st_r.wr_v != 3'h0) ##1 (pre_bank == $past(wr_bank)) |-> !pre_ok)
    else $error("precharge allowed right after write");

  a_wtr_read: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write && st_r.wtr_v != 3'h0) |=> !rd_ok)
    else $error("read allowed right after write");

  a_xp_block: assert property (@(posedge pclk) disable iff (!presetn)
    (pd_exit && st_r.xp_v != 8'h00) |=> !cmd_any_ok)
    else $error("command allowed after power-down exit");

  a_xsr_block: assert property (@(posedge pclk) disable iff (!presetn)
    (sr_exit && st_r.xsr_v != 8'h00) |=> !cmd_any_ok)
    else $error("command allowed after self-refresh exit");

  a_esr_block: assert property (@(posedge pclk) disable iff (!presetn)
    (sr_entry && st_r.esr_v != 8'h00) |=> !cmd_any_ok)
    else $error("command allowed after self-refresh entry");

  a_locked_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access and (pwrite && !win)) |=> $stable(st_r.xp_v) && $stable(st_r.rfc_v))
    else $error("locked write changed a register");

  a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.xp_c != 8'h00 && !pd_exit) |=> st_r.xp_c == $past(st_r.xp_c) - 8'h01)
    else $error("spacing counter did not step down");

  a_open_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_open ##1 s_access |-> !pslverr)
    else $error("open timing access flagged as error");

  a_locked_rdata: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_locked ##1 s_access |-> prdata == 32'h0000_0000)
    else $error("locked timing read returned data");

  a_xp_commit: assert property (@(posedge pclk) disable iff (!presetn)
    (s_access and (pwrite && win && paddr == sdcts_pkg::OFS_XP))
      |=> st_r.xp_v == $past(pwdata[7:0]))
    else $error("open write did not land");

  a_status_open: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == sdcts_pkg::OFS_STATUS) ##1 s_access
      |-> prdata[10] == $past(win))
    else $error("status window bit wrong");

  a_rfc_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_refresh |=> st_r.rfc_c == $past(st_r.rfc_v))
    else $error("refresh recovery counter not loaded");

  a_srfc_three: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_refresh && st_r.srfc_v == 5'h00) |=> !cmd_any_ok [*3])
    else $error("scheduler refresh spacing under three");

  a_rp_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_precharge |=> st_r.rp_c == $past(st_r.rp_v))
    else $error("precharge recovery counter not loaded");

  a_srp_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_precharge |=> st_r.srp_c == {1'b0, $past(st_r.srp_v)} + 4'h3)
    else $error("scheduler precharge spacing wrong");

  a_rrd_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_activate |=> st_r.rrd_c == $past(st_r.rrd_v) && st_r.rrd_bank == $past(act_bank))
    else $error("cross-bank counter or bank not loaded");

  a_wr_load: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_write |=> st_r.wr_c == $past(st_r.wr_v) && st_r.wtr_c == $past(st_r.wtr_v))
    else $error("write counters not loaded");

  a_xp_load: assert property (@(posedge pclk) disable iff (!presetn)
    pd_exit |=> st_r.xp_c == $past(st_r.xp_v))
    else $error("power-down exit counter not loaded");

  a_xsr_load: assert property (@(posedge pclk) disable iff (!presetn)
    sr_exit |=> st_r.xsr_c == $past(st_r.xsr_v))
    else $error("self-refresh exit counter not loaded");

  a_esr_load: assert property (@(posedge pclk) disable iff (!presetn)
    sr_entry |=> st_r.esr_c == $past(st_r.esr_v))
    else $error("self-refresh entry counter not loaded");

endmodule

// *** verilog/sdcts_pkg.sv ***
package sdcts_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_RFC = 12'h000;
  localparam logic [11:0] OFS_RP = 12'h004;
  localparam logic [11:0] OFS_RRD = 12'h008;
  localparam logic [11:0] OFS_WR = 12'h00c;
  localparam logic [11:0] OFS_WTR = 12'h010;
  localparam logic [11:0] OFS_XP = 12'h014;
  localparam logic [11:0] OFS_XSR = 12'h018;
  localparam logic [11:0] OFS_ESR = 12'h01c;
  localparam logic [11:0] OFS_STATUS = 12'h020;
  // Field positions
  localparam int RFC_LSB = 0;
  localparam int SRFC_LSB = 5;
  localparam int RP_LSB = 0;
  localparam int SRP_LSB = 3;
  // Values after reset
  localparam logic [4:0] RST_RFC = 5'h1f;
  localparam logic [4:0] RST_SRFC = 5'h1f;
  localparam logic [2:0] RST_RP = 3'h7;
  localparam logic [2:0] RST_SRP = 3'h7;
  localparam logic [3:0] RST_RRD = 4'hf;
  localparam logic [2:0] RST_WR = 3'h7;
  localparam logic [2:0] RST_WTR = 3'h7;
  localparam logic [7:0] RST_XP = 8'hff;
  localparam logic [7:0] RST_XSR = 8'hff;
  localparam logic [7:0] RST_ESR = 8'hff;
  // Scheduler spacing is the field plus this many bus cycles
  localparam logic [5:0] SCHED_ADD = 6'h03;
endpackage

// *** bench/sdcts_cmd_model.sv ***
`timescale 1ns/10ps
module sdcts_cmd_model (
  // Clock
  input wire logic pclk,
  // Requests from the bench
  input wire logic [6:0] go,
  input wire logic [1:0] bank,
  // Commands toward the timing block
  output logic [6:0] cmd,
  output logic [1:0] cmd_bank
);
  // Bank registered with its pulse, so a bank change lands after issue
  always_ff @(posedge pclk) begin
    cmd <= go;
    cmd_bank <= bank;
  end
endmodule

// *** bench/sdram_command_timing_regs_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %0h want %0h", $time, (a), (b)); end end
module sdram_command_timing_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic ctl_config, ctl_low_power, cmd_any_ok, act_ok, pre_ok, rd_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] go, cmd;
  logic [1:0] gbank, cbank;
  int n_errors = 0;
  int total_checks = 0;
  wire [3:0] oks = {rd_ok, pre_ok, act_ok, cmd_any_ok};

  sdcts_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctl_config(ctl_config), .ctl_low_power(ctl_low_power),
    .cmd_refresh(cmd[0]), .cmd_precharge(cmd[1]), .pre_bank(cbank), .cmd_activate(cmd[2]),
    .act_bank(cbank), .cmd_write(cmd[3]), .wr_bank(cbank), .pd_exit(cmd[4]),
    .sr_exit(cmd[5]), .sr_entry(cmd[6]), .cmd_any_ok(cmd_any_ok), .act_ok(act_ok),
    .pre_ok(pre_ok), .rd_ok(rd_ok));
  sdcts_cmd_model model (.pclk(pclk), .go(go), .bank(gbank), .cmd(cmd), .cmd_bank(cbank));

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    `CHK(n, 1)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chkrd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(err, ee)
  endtask

  // Counts low cycles of each permit after one issued event
  task automatic fire(input logic [6:0] ev, input logic [1:0] b, nb,
                      input int e0, e1, e2, e3);
    int c[4];
    int lim;
    c = '{0, 0, 0, 0};
    lim = 0;
    @(posedge pclk);
    go <= ev;
    gbank <= b;
    @(posedge pclk);
    go <= 7'h00;
    gbank <= nb;
    @(posedge pclk);
    #1;
    while (oks !== 4'hf && lim < 300) begin
      for (int k = 0; k < 4; k++) c[k] += (oks[k] === 1'b0);
      lim++;
      @(posedge pclk);
      #1;
    end
    `CHK(lim < 300, 1'b1)
    if (e0 >= 0) `CHK(c[0], e0)
    if (e1 >= 0) `CHK(c[1], e1)
    if (e2 >= 0) `CHK(c[2], e2)
    if (e3 >= 0) `CHK(c[3], e3)
    // Realign so the next request starts on an edge
    @(posedge pclk);
  endtask

  task automatic reset_values();
    logic [31:0] rv [8] = '{32'h3ff, 32'h3f, 32'hf, 32'h7, 32'h7, 32'hff, 32'hff, 32'hff};
    for (int i = 0; i < 8; i++) chkrd(12'(4 * i), rv[i], 1'b0);
    chkrd(12'h020, 32'h400, 1'b0);
  endtask

  task automatic window();
    ctl_config <= 1'b0;
    apb(1'b1, 12'h014, 32'h5);
    chkrd(12'h014, 32'h0, 1'b1);
    chkrd(12'h020, 32'h0, 1'b0);
    chkrd(12'h030, 32'h0, 1'b1);
    ctl_low_power <= 1'b1;
    chkrd(12'h014, 32'hff, 1'b0);
    apb(1'b1, 12'h014, 32'h6);
    chkrd(12'h014, 32'h6, 1'b0);
    ctl_config <= 1'b1;
  endtask

  task automatic spacing();
    fire(7'h01, 0, 0, 34, -1, -1, -1);
    apb(1'b1, 12'h000, 32'h2);
    fire(7'h01, 0, 0, 3, -1, -1, -1);
    apb(1'b1, 12'h000, 32'h5);
    fire(7'h01, 0, 0, 5, -1, -1, -1);
    fire(7'h02, 0, 0, -1, 10, -1, -1);
    apb(1'b1, 12'h004, 32'h11);
    fire(7'h02, 0, 0, -1, 5, -1, -1);
    apb(1'b1, 12'h004, 32'h7);
    fire(7'h02, 0, 0, -1, 7, -1, -1);
  endtask

  task automatic bank_rules();
    apb(1'b1, 12'h008, 32'h4);
    fire(7'h04, 0, 0, -1, 0, -1, -1);
    fire(7'h04, 0, 1, -1, 4, -1, -1);
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b1, 12'h010, 32'h2);
    fire(7'h08, 2, 2, -1, -1, 3, 2);
    fire(7'h08, 2, 1, -1, -1, 0, 2);
  endtask

  task automatic exits();
    apb(1'b1, 12'h018, 32'h1);
    fire(7'h10, 0, 0, 6, -1, -1, -1);
    fire(7'h20, 0, 0, 1, -1, -1, -1);
    fire(7'h40, 0, 0, 255, -1, -1, -1);
  endtask

  // Reset in mid-count clears every spacing and restores the values
  task automatic mid_reset();
    apb(1'b1, 12'h014, 32'h9);
    go <= 7'h40;
    @(posedge pclk);
    go <= 7'h00;
    @(posedge pclk);
    chkrd(12'h020, 32'h600, 1'b0);
    #1;
    `CHK(cmd_any_ok, 1'b0)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    `CHK(oks, 4'hf)
    @(posedge pclk);
    presetn <= 1'b1;
    chkrd(12'h014, 32'hff, 1'b0);
    chkrd(12'h020, 32'h400, 1'b0);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Whole run is near 480 cycles
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ctl_config = 1'b1;
    ctl_low_power = 1'b0;
    go = 7'h00;
    gbank = 2'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    window();
    spacing();
    bank_rules();
    exits();
    mid_reset();
    finish_test();
  end
endmodule
